//--- hw/peak_current_pwm_core.sv
// oscillator, gate pulse, soft-start, overpower and overload protection
//
// Summary of operation
// R01: oscillator 65 or 100 kHz by option
// R02: gate never high beyond 80 percent period
// R03: period jitters plus/minus six percent at 125 Hz
// R04: jitter also applies at light-load frequency
// R05: ignore current sense for 250 ns after turn-on
// R06: trip threshold is loop setpoint over five
// R07: 0.7 V limit comparator always ends pulse; the code ignores it inside the 32-cycle blanking, like the trip comparator
// R08: soft-start ramp on every start, lower wins
// R09: soft-start ramp advances in 15 steps
// R10: runaway stop level enters protection immediately
// R11: compensation enabled only above enable level
// R12: line code sampled and cleared each event
// R13: 32 ms watchdog makes events without line
// R14: setpoint falls with on-time, slope per option
// R15: overload timer at limit, expiry stops pulses
// R16: overload timer cleared when setpoint drops below
// R17: max-duty ended pulse never starts overload timer
// R18: autorecovery waits retry delay, then soft-starts
// R19: latched option stays off until supply reset
// R20: supply stop level turns off, clears timer
// R21: comparator outputs pass two-flop synchronisers
// R22: gate rises at period start only running
`timescale 1ns/1ps
module peak_current_pwm_core
  import pwm_core_pkg::*;
#(
  parameter bit FREQ_100K = 1'b0,
  parameter bit AUTO_RECOVERY = 1'b0,
  parameter int SS_STEP_CYC = SS_STEP_CYC_DEF,
  parameter int WD_CYC = WD_CYC_DEF,
  parameter int OVERLOAD_CYC = OVERLOAD_CYC_DEF,
  parameter int RETRY_CYC = RETRY_CYC_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_vcc_start,
  input wire logic i_vcc_stop,
  input wire logic i_light_load,
  input wire logic [12:0] i_loop_setpoint_input_mv,
  input wire logic i_cs_trip,
  input wire logic i_limit_trip,
  input wire logic i_runaway_trip,
  input wire logic i_line_sample_compare,
  input wire logic i_above_comp_enable_level,
  input wire logic [2:0] i_line_sense_code,
  output logic o_gate_drive_out,
  output logic [20:0] o_cs_setpoint_uv,
  output logic o_comp_enable,
  output logic [2:0] o_line_code,
  output logic o_line_clear,
  output logic o_running,
  output logic o_retry_wait,
  output logic o_latched
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  state_e state_q;
  logic [4:0] sync_s;
  logic cs_s, lim_s, stop_s, samp_s, lvl_s;
  logic samp_d_q;
  logic [12:0] per_cnt_q, per_len_q, max_on_q, on_cnt_q;
  logic [12:0] per_base, per_next, max_on_d;
  logic per_start;
  logic signed [8:0] jit_q;
  logic jit_up_q;
  logic [11:0] jit_cnt_q;
  logic [8:0] jit_amp;
  logic [11:0] jit_step;
  logic blank_done, cmp_end, duty_end;
  logic [3:0] ss_step_q;
  logic [CNT_W-1:0] ss_cnt_q, ovl_cnt_q, retry_cnt_q, wd_cnt_q;
  logic [20:0] loop_uv, ss_uv, slope_uv, sp_loop, sp_d, slope_c;
  logic clamp, ovl_arm_q, ovl_done, retry_done;
  logic line_evt, wd_evt, samp_evt;

  // lower of two levels, used for setpoint and clamp
  function automatic logic [20:0] umin(input logic [20:0] a,
                                       input logic [20:0] b);
    umin = (a < b) ? a : b;
  endfunction

  // -----------------------------------------------------------------
  // comparator synchronisers
  // -----------------------------------------------------------------
  sync_bank #(.W(5)) u_sync ( // R21
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_cs_trip, i_limit_trip, i_runaway_trip,
              i_line_sample_compare, i_above_comp_enable_level}),
    .o_sync(sync_s)
  );
  assign {cs_s, lim_s, stop_s, samp_s, lvl_s} = sync_s;

  // -----------------------------------------------------------------
  // oscillator with triangular jitter
  // -----------------------------------------------------------------
  // nominal period by light-load input or build option, jitter constants by build option
  assign per_base = i_light_load ? PER_LIGHT : // R04
                    (FREQ_100K ? PER_100 : PER_65); // R01
  assign jit_amp = FREQ_100K ? JIT_AMP_100 : JIT_AMP_65;
  assign jit_step = FREQ_100K ? JIT_STEP_100 : JIT_STEP_65;
  assign per_next = 13'(14'(per_base) + 14'(jit_q)); // R03
  assign max_on_d = 13'((16'(per_next) * 16'(DUTY_NUM)) / 16'(DUTY_DEN));
  assign per_start = (per_cnt_q == per_len_q - 13'h1);

  // triangle walks between -amp and +amp, one step per jit_step cycles
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      jit_q <= 9'sh0;
      jit_up_q <= 1'b1;
      jit_cnt_q <= 12'h0;
    end else if (jit_cnt_q == jit_step - 12'h1) begin
      jit_cnt_q <= 12'h0;
      if (jit_up_q) begin
        jit_q <= jit_q + 9'sh1; // R03
        if (jit_q == $signed(jit_amp) - 9'sh1) begin
          jit_up_q <= 1'b0;
        end
      end else begin
        jit_q <= jit_q - 9'sh1;
        if (jit_q == 9'sh1 - $signed(jit_amp)) begin
          jit_up_q <= 1'b1;
        end
      end
    end else begin
      jit_cnt_q <= jit_cnt_q + 12'h1;
    end
  end

  // period counter; next length and duty cap latched at wrap
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      per_cnt_q <= 13'h0;
      per_len_q <= PER_65;
      max_on_q <= 13'h0;
    end else if (per_start) begin
      per_cnt_q <= 13'h0;
      per_len_q <= per_next;
      max_on_q <= max_on_d; // R02
    end else begin
      per_cnt_q <= per_cnt_q + 13'h1;
    end
  end

  // -----------------------------------------------------------------
  // gate pulse
  // -----------------------------------------------------------------
  assign blank_done = (on_cnt_q >= BLANK_CYC); // R05
  assign cmp_end = o_gate_drive_out && blank_done && (cs_s || lim_s);
  assign duty_end = o_gate_drive_out && !cmp_end &&
                    (on_cnt_q >= max_on_q - 13'h1);

  // on-time counter, zero in first high cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      on_cnt_q <= 13'h0;
    end else if (!o_gate_drive_out) begin
      on_cnt_q <= 13'h0;
    end else begin
      on_cnt_q <= on_cnt_q + 13'h1;
    end
  end

  // set at period start, reset by comparators or duty cap
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_gate_drive_out <= 1'b0;
    end else if (state_q != ST_RUN || stop_s || i_vcc_stop) begin
      o_gate_drive_out <= 1'b0;
    end else if (per_start) begin
      o_gate_drive_out <= 1'b1; // R22
    end else if (cmp_end) begin
      o_gate_drive_out <= 1'b0; // R06 R07
    end else if (duty_end) begin
      o_gate_drive_out <= 1'b0; // R02
    end
  end

  // -----------------------------------------------------------------
  // setpoint: loop demand, slope, soft-start, limit
  // -----------------------------------------------------------------
  assign slope_c = FREQ_100K ? SLOPE_100_CYC : SLOPE_65_CYC;
  assign loop_uv = 21'(i_loop_setpoint_input_mv) * LOOP_UV_PER_MV; // R06
  assign slope_uv = 21'(on_cnt_q) * slope_c; // R14
  assign sp_loop = (loop_uv > slope_uv) ? loop_uv - slope_uv : 21'h0;
  assign ss_uv = (ss_step_q == SS_STEPS) ? PEAK_LIMIT_UV :
                 21'(ss_step_q) * SS_STEP_UV; // R09
  assign sp_d = umin(umin(sp_loop, ss_uv), PEAK_LIMIT_UV); // R08
  assign clamp = (umin(loop_uv, ss_uv) >= PEAK_LIMIT_UV); // R15

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cs_setpoint_uv <= 21'h0;
    end else begin
      o_cs_setpoint_uv <= sp_d;
    end
  end

  // staircase ramp restarts whenever the core is not running
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ss_step_q <= 4'h0;
      ss_cnt_q <= '0;
    end else if (state_q != ST_RUN) begin
      ss_step_q <= 4'h0; // R08
      ss_cnt_q <= '0;
    end else if (ss_step_q != SS_STEPS) begin
      if (ss_cnt_q == CNT_W'(SS_STEP_CYC - 1)) begin
        ss_cnt_q <= '0;
        ss_step_q <= ss_step_q + 4'h1; // R09
      end else begin
        ss_cnt_q <= ss_cnt_q + 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // overload timer
  // -----------------------------------------------------------------
  assign ovl_done = (ovl_cnt_q == CNT_W'(OVERLOAD_CYC - 1));

  // armed only by a comparator-ended pulse while clamped
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ovl_arm_q <= 1'b0;
    end else if (state_q != ST_RUN || !clamp) begin
      ovl_arm_q <= 1'b0; // R16 R20
    end else if (cmp_end) begin
      ovl_arm_q <= 1'b1; // R15 R17
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ovl_cnt_q <= '0;
    end else if (state_q != ST_RUN || !clamp || i_vcc_stop) begin
      ovl_cnt_q <= '0; // R16 R20
    end else if (ovl_arm_q && !ovl_done) begin
      ovl_cnt_q <= ovl_cnt_q + 1'b1; // R15
    end
  end

  // -----------------------------------------------------------------
  // controller state
  // -----------------------------------------------------------------
  assign retry_done = (retry_cnt_q == CNT_W'(RETRY_CYC - 1));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      retry_cnt_q <= '0;
    end else if (state_q != ST_RETRY) begin
      retry_cnt_q <= '0;
    end else begin
      retry_cnt_q <= retry_cnt_q + 1'b1; // R18
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: begin
          if (i_vcc_start && !i_vcc_stop) begin
            state_q <= ST_RUN; // R08
          end
        end
        ST_RUN: begin
          if (stop_s || (ovl_done && ovl_arm_q && !i_vcc_stop)) begin
            state_q <= AUTO_RECOVERY ? ST_RETRY : ST_LATCH; // R10 R15
          end else if (i_vcc_stop) begin
            state_q <= ST_OFF; // R20
          end
        end
        ST_RETRY: begin
          if (i_vcc_stop) begin
            state_q <= ST_OFF; // R20
          end else if (retry_done) begin
            state_q <= ST_RUN; // R18
          end
        end
        ST_LATCH: begin
          state_q <= ST_LATCH; // R19
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // overpower compensation and line sampling
  // -----------------------------------------------------------------
  assign line_evt = samp_s && !samp_d_q;
  assign wd_evt = (wd_cnt_q == CNT_W'(WD_CYC - 1)); // R13
  assign samp_evt = line_evt || wd_evt;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      samp_d_q <= 1'b0;
    end else begin
      samp_d_q <= samp_s;
    end
  end

  // watchdog restarts on every sample event
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wd_cnt_q <= '0;
    end else if (samp_evt) begin
      wd_cnt_q <= '0; // R13
    end else begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // capture converter code, then clear its peak detector
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_line_code <= 3'h0;
      o_line_clear <= 1'b0;
    end else begin
      o_line_clear <= samp_evt; // R12
      if (samp_evt) begin
        o_line_code <= i_line_sense_code; // R12
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_comp_enable <= 1'b0;
    end else begin
      o_comp_enable <= lvl_s && (state_q == ST_RUN); // R11
    end
  end

  // status levels
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_running <= 1'b0;
      o_retry_wait <= 1'b0;
      o_latched <= 1'b0;
    end else begin
      o_running <= (state_q == ST_RUN);
      o_retry_wait <= (state_q == ST_RETRY);
      o_latched <= (state_q == ST_LATCH);
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_gate_on;
    o_gate_drive_out && on_cnt_q < BLANK_CYC - 13'h1;
  endsequence
  sequence s_sample;
    samp_evt ##1 o_line_clear;
  endsequence

  duty_cap_a: assert property ( // R02
    o_gate_drive_out |-> on_cnt_q < max_on_q)
    else $error("gate high past duty cap");
  blank_hold_a: assert property ( // R05
    s_gate_on and (state_q == ST_RUN && !stop_s && !i_vcc_stop)
      |=> o_gate_drive_out)
    else $error("pulse ended inside blanking");
  trip_end_a: assert property ( // R06
    o_gate_drive_out && blank_done && cs_s |=> !o_gate_drive_out)
    else $error("current trip did not end pulse");
  limit_end_a: assert property ( // R07
    o_gate_drive_out && blank_done && lim_s |=> !o_gate_drive_out)
    else $error("limit trip did not end pulse");
  ss_range_a: assert property ( // R08
    state_q != ST_RUN |=> ss_step_q == 4'h0 && ss_uv == 21'h0)
    else $error("soft-start not restarted");
  runaway_a: assert property ( // R10
    state_q == ST_RUN && stop_s
      |=> (state_q == ST_RETRY || state_q == ST_LATCH) && !o_gate_drive_out)
    else $error("runaway stop ignored");
  comp_en_a: assert property ( // R11
    o_comp_enable |-> $past(lvl_s))
    else $error("compensation on below enable level");
  line_samp_a: assert property ( // R12
    s_sample |-> o_line_code == $past(i_line_sense_code))
    else $error("line code not captured");
  wd_bound_a: assert property ( // R13
    wd_cnt_q < CNT_W'(WD_CYC))
    else $error("watchdog overran");
  ovl_clear_a: assert property ( // R16
    !clamp |=> ovl_cnt_q == '0)
    else $error("overload timer kept below limit");
  duty_noarm_a: assert property ( // R17
    duty_end && !ovl_arm_q |=> !ovl_arm_q)
    else $error("duty end armed overload timer");
  latch_hold_a: assert property ( // R19
    state_q == ST_LATCH |=> state_q == ST_LATCH [*8])
    else $error("latched state left");
  vcc_stop_a: assert property ( // R20
    i_vcc_stop && state_q == ST_RUN && !stop_s |=> state_q == ST_OFF
      ##0 ovl_cnt_q == '0)
    else $error("supply stop did not turn off");
  gate_rise_a: assert property ( // R22
    $rose(o_gate_drive_out) |-> $past(per_start && state_q == ST_RUN))
    else $error("gate rose outside period start");

endmodule

//--- hw/pwm_core_pkg.sv
// constants, timing figures and state codes of the peak current pwm core
package pwm_core_pkg;

  // -----------------------------------------------------------------
  // clock and oscillator
  // -----------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_NS = 8;
  localparam int PER_W = 13;
  localparam int F_LOW_OPT_HZ = 65_000;
  localparam int F_HIGH_OPT_HZ = 100_000;
  localparam int F_LIGHT_HZ = 27_000;
  localparam logic [12:0] PER_65 = 13'(CLK_HZ / F_LOW_OPT_HZ);
  localparam logic [12:0] PER_100 = 13'(CLK_HZ / F_HIGH_OPT_HZ);
  localparam logic [12:0] PER_LIGHT = 13'(CLK_HZ / F_LIGHT_HZ);
  localparam int DUTY_NUM = 4;
  localparam int DUTY_DEN = 5;

  // -----------------------------------------------------------------
  // triangular period modulation
  // -----------------------------------------------------------------
  localparam int JIT_PCT = 6;
  localparam int JIT_MOD_HZ = 125;
  localparam int MOD_CYC = CLK_HZ / JIT_MOD_HZ;
  localparam int JIT_65 = 1923 * JIT_PCT / 100;
  localparam int JIT_100 = 1250 * JIT_PCT / 100;
  localparam logic [8:0] JIT_AMP_65 = 9'(JIT_65);
  localparam logic [8:0] JIT_AMP_100 = 9'(JIT_100);
  localparam logic [11:0] JIT_STEP_65 = 12'(MOD_CYC / (4 * JIT_65));
  localparam logic [11:0] JIT_STEP_100 = 12'(MOD_CYC / (4 * JIT_100));

  // -----------------------------------------------------------------
  // current sense levels, in microvolts
  // -----------------------------------------------------------------
  localparam int UV_W = 21;
  localparam int BLANK_NS = 250;
  localparam logic [12:0] BLANK_CYC = 13'((BLANK_NS + CLK_NS - 1) / CLK_NS);
  localparam int SP_DIV = 5;
  localparam int UV_PER_MV = 1000;
  localparam logic [20:0] LOOP_UV_PER_MV = 21'(UV_PER_MV / SP_DIV);
  localparam logic [20:0] PEAK_LIMIT_UV = 21'h0aae60;
  localparam logic [20:0] RUNAWAY_STOP_UV = 21'((700_000 * 3) / 2);
  localparam int SLOPE_65_UV_US = 32_500;
  localparam int SLOPE_100_UV_US = 50_000;
  localparam logic [20:0] SLOPE_65_CYC = 21'(SLOPE_65_UV_US * CLK_NS / 1000);
  localparam logic [20:0] SLOPE_100_CYC =
    21'(SLOPE_100_UV_US * CLK_NS / 1000);

  // -----------------------------------------------------------------
  // soft-start, watchdog, protection timers
  // -----------------------------------------------------------------
  localparam int CNT_W = 28;
  localparam logic [3:0] SS_STEPS = 4'hf;
  localparam logic [20:0] SS_STEP_UV = 21'(700_000 / 15);
  localparam int RAMP_UP_US = 4000;
  localparam int SS_STEP_CYC_DEF = RAMP_UP_US * (CLK_HZ / 1_000_000) / 15;
  localparam int WD_MS = 32;
  localparam int WD_CYC_DEF = WD_MS * (CLK_HZ / 1000);
  localparam int OVERLOAD_MS = 128;
  localparam int OVERLOAD_CYC_DEF = OVERLOAD_MS * (CLK_HZ / 1000);
  localparam int RETRY_MS = 1000;
  localparam int RETRY_CYC_DEF = RETRY_MS * (CLK_HZ / 1000);

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_RUN = 4'h2,
    ST_RETRY = 4'h4,
    ST_LATCH = 4'h8
  } state_e;

endpackage

//--- hw/sync_bank.sv
// bank of two-flop synchronisers for asynchronous comparator outputs
`timescale 1ns/1ps
module sync_bank #(
  parameter int W = 5
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_q[g] <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          meta_q[g] <= i_async[g];
          o_sync[g] <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule

//--- testbench/switch_sense_model.sv
// model of the power switch and sense resistor feeding the comparators
`timescale 1ns/1ps
module switch_sense_model (
  input wire logic i_clk,
  input wire logic i_gate,
  input wire logic [20:0] i_setpoint_uv,
  input wire logic [20:0] i_rise_uv,
  output logic o_cs_trip,
  output logic o_limit_trip,
  output logic o_runaway_trip
);
  logic [31:0] sense_q;
  initial sense_q = '0;
  // current ramps while the switch conducts and falls to zero when off
  always @(posedge i_clk) begin
    if (i_gate === 1'b1) begin
      sense_q <= #1 sense_q + 32'(i_rise_uv);
    end else begin
      sense_q <= #1 '0;
    end
  end
  // comparators change between clock edges, as real ones would
  assign o_cs_trip = sense_q >= 32'(i_setpoint_uv);
  assign o_limit_trip = sense_q >= 32'h000aae60; // 0.7 V
  assign o_runaway_trip = sense_q >= 32'h00100590; // 1.05 V
endmodule

//--- testbench/testbench.sv
// self-checking bench of the peak current pwm core
`timescale 1ns/1ps
module testbench;
  import pwm_core_pkg::*;
  localparam int WDC = 200;
  logic i_clk, i_rst_b, i_vcc_start, i_vcc_stop, i_light_load;
  logic [12:0] i_loop_setpoint_input_mv;
  logic i_cs_trip, i_limit_trip, i_runaway_trip;
  logic i_line_sample_compare, i_above_comp_enable_level;
  logic [2:0] i_line_sense_code, o_line_code;
  logic o_gate_drive_out, o_comp_enable, o_line_clear;
  logic o_running, o_retry_wait, o_latched;
  logic [20:0] o_cs_setpoint_uv, rise, sp_a;
  logic [2:0] code_q[$];
  int bad_count, compares, n, m;
  logic gate2, cs2, lim2, run2, running2, retry2, latched2;
  logic [20:0] sp2;

  peak_current_pwm_core #(.SS_STEP_CYC(20), .WD_CYC(WDC),
    .OVERLOAD_CYC(300), .RETRY_CYC(100)) DUT (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_vcc_start(i_vcc_start),
    .i_vcc_stop(i_vcc_stop), .i_light_load(i_light_load),
    .i_loop_setpoint_input_mv(i_loop_setpoint_input_mv),
    .i_cs_trip(i_cs_trip), .i_limit_trip(i_limit_trip),
    .i_runaway_trip(i_runaway_trip),
    .i_line_sample_compare(i_line_sample_compare),
    .i_above_comp_enable_level(i_above_comp_enable_level),
    .i_line_sense_code(i_line_sense_code),
    .o_gate_drive_out(o_gate_drive_out),
    .o_cs_setpoint_uv(o_cs_setpoint_uv), .o_comp_enable(o_comp_enable),
    .o_line_code(o_line_code), .o_line_clear(o_line_clear),
    .o_running(o_running), .o_retry_wait(o_retry_wait),
    .o_latched(o_latched));

  switch_sense_model partner (.i_clk(i_clk), .i_gate(o_gate_drive_out),
    .i_setpoint_uv(o_cs_setpoint_uv), .i_rise_uv(rise),
    .o_cs_trip(i_cs_trip), .o_limit_trip(i_limit_trip),
    .o_runaway_trip(i_runaway_trip));

  // second build: 100 kHz option with autorecovery, same stimulus
  peak_current_pwm_core #(.FREQ_100K(1'b1), .AUTO_RECOVERY(1'b1),
    .SS_STEP_CYC(20), .WD_CYC(WDC), .OVERLOAD_CYC(300),
    .RETRY_CYC(100)) DUT2 (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_vcc_start(i_vcc_start),
    .i_vcc_stop(i_vcc_stop), .i_light_load(i_light_load),
    .i_loop_setpoint_input_mv(i_loop_setpoint_input_mv),
    .i_cs_trip(cs2), .i_limit_trip(lim2), .i_runaway_trip(run2),
    .i_line_sample_compare(i_line_sample_compare),
    .i_above_comp_enable_level(i_above_comp_enable_level),
    .i_line_sense_code(i_line_sense_code),
    .o_gate_drive_out(gate2), .o_cs_setpoint_uv(sp2), .o_comp_enable(),
    .o_line_code(), .o_line_clear(), .o_running(running2),
    .o_retry_wait(retry2), .o_latched(latched2));

  switch_sense_model partner2 (.i_clk(i_clk), .i_gate(gate2),
    .i_setpoint_uv(sp2), .i_rise_uv(rise), .o_cs_trip(cs2),
    .o_limit_trip(lim2), .o_runaway_trip(run2));

  // -----------------------------------------------------------------
  // clock, helpers and verdict
  // -----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // waits for the next gate pulse and returns its length in cycles
  task automatic gate_pulse(output int len);
    int t;
    len = 0;
    t = 0;
    while (o_gate_drive_out !== 1'b1 && t < 20000) begin
      tick(1);
      t++;
    end
    while (o_gate_drive_out === 1'b1 && len < 20000) begin
      tick(1);
      len++;
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watcher takes the oldest expected line code at each clear pulse
  initial begin
    forever begin
      @(posedge i_clk);
      #2;
      if (o_line_clear === 1'b1 && code_q.size() > 0) begin
        check("line_code", 32'(code_q.pop_front()), 32'(o_line_code));
      end
    end
  end

  // watchdog against a hang
  initial begin
    #(8 * 90000);
    bad_count++;
    finish_test();
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    i_rst_b = 1'b0;
    i_vcc_start = 1'b0;
    i_vcc_stop = 1'b0;
    i_light_load = 1'b0;
    i_loop_setpoint_input_mv = 13'h1388; // 5000 mV, demand above limit
    i_line_sample_compare = 1'b0;
    i_above_comp_enable_level = 1'b0;
    i_line_sense_code = 3'h0;
    rise = 21'h0;
    bad_count = 0;
    compares = 0;
    void'($urandom(32'ha0996ac8));
    tick(2);
    check("gate_in_reset", 0, 32'(o_gate_drive_out));
    i_rst_b = 1'b1;
    i_vcc_start = 1'b1;
    tick(400);
    check("running", 1, 32'(o_running));
    // no trip: pulses end by the duty limit and never arm overload
    repeat (3) begin
      gate_pulse(n);
      check("max_duty", 1, 32'(n >= 1446 && n <= 1630));
    end
    check("no_overload", 0, 32'(o_latched));
    i_light_load = 1'b1;
    gate_pulse(n);
    gate_pulse(n);
    check("light_on_time", 1, 32'(n >= 3000 && n <= 3800));
    i_light_load = 1'b0;
    i_loop_setpoint_input_mv = 13'h07d0;
    // sense passes trip level inside blanking: only blanking holds the gate
    rise = 21'h061a8;
    gate_pulse(n);
    check("blanking", 1, 32'(n >= 32 && n <= 36));
    // loop setpoint over five and slope during on-time
    rise = 21'h0;
    m = 1000 + int'($urandom_range(2000));
    i_loop_setpoint_input_mv = 13'(m);
    gate_pulse(n);
    tick(5);
    check("setpoint", 32'(m * 200), 32'(o_cs_setpoint_uv));
    while (o_gate_drive_out !== 1'b1) tick(1);
    tick(10);
    sp_a = o_cs_setpoint_uv;
    tick(10);
    check("slope", 32'(2600), 32'(sp_a - o_cs_setpoint_uv));
    // compensation enable follows the level with three edges latency
    i_above_comp_enable_level = 1'b1;
    tick(2);
    check("comp_early", 0, 32'(o_comp_enable));
    tick(1);
    check("comp_on", 1, 32'(o_comp_enable));
    i_above_comp_enable_level = 1'b0;
    tick(3);
    check("comp_off", 0, 32'(o_comp_enable));
    // line sample events, then none so the watchdog takes over
    repeat (4) begin
      i_line_sense_code = 3'($urandom);
      code_q.push_back(i_line_sense_code);
      i_line_sample_compare = 1'b1;
      tick(4);
      i_line_sample_compare = 1'b0;
      tick(10);
      check("line_events", 0, 32'(code_q.size()));
    end
    i_line_sense_code = 3'($urandom);
    code_q.push_back(i_line_sense_code);
    tick(WDC + 20);
    check("watchdog", 0, 32'(code_q.size()));
    // supply stop turns the controller off, then it starts again
    i_vcc_stop = 1'b1;
    tick(3);
    check("stop_off", 0, 32'(o_running || o_gate_drive_out));
    i_vcc_stop = 1'b0;
    tick(400);
    check("restart", 1, 32'(o_running));
    // overload: limit comparator ends pulses while clamped
    i_loop_setpoint_input_mv = 13'h1388;
    rise = 21'h01388;
    n = 0;
    while (o_latched !== 1'b1 && n < 8000) begin
      tick(1);
      n++;
    end
    check("overload_latch", 1, 32'(o_latched));
    tick(2000);
    check("latch_holds", 1, 32'(o_latched && !o_gate_drive_out));
    // second reset clears the latch; runaway enters protection at once
    i_rst_b = 1'b0;
    tick(2);
    i_rst_b = 1'b1;
    i_loop_setpoint_input_mv = 13'h07d0;
    rise = 21'h0c350;
    tick(400);
    check("reset_release", 0, 32'(o_latched));
    gate_pulse(n);
    tick(4);
    check("runaway", 1, 32'(o_latched && n < 36));
    // both builds pulse together after reset, so the second one stops too
    check("retry_wait", 1, 32'(retry2 && !latched2));
    tick(97);
    check("retry_restart", 1, 32'(running2 && !retry2 && sp2 == 21'h0));
    finish_test();
  end
endmodule
